// [hdl/wdh_pkg.sv]
package wdh_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PCLK_HZ = 100_000_000;
  localparam int unsigned SYSCLK_FAST_HZ = 12_000_000;
  localparam int unsigned SYSCLK_SLOW_HZ = 6_000_000;
  localparam int unsigned SYS_FAST_CYC = PCLK_HZ / SYSCLK_FAST_HZ;
  localparam int unsigned SYS_SLOW_CYC = PCLK_HZ / SYSCLK_SLOW_HZ;
  localparam int unsigned RC_PERIOD_NS = 31000;
  localparam int unsigned RC_CYC = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned INSTR_DIV = 4;
  localparam int unsigned SST_TICKS = 1024;

  // Watchdog divider chain: 8 base stages plus up to 7 prescaler stages
  localparam int unsigned BASE_STAGES = 8;
  localparam int unsigned CNT_W = 15;

  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PRESCALE_CTRL = 8'h09;
  localparam logic [7:0] IDX_STATUS = 8'h0a;
  localparam logic [7:0] IDX_CLOCK_CTRL = 8'h10;
  localparam logic [11:0] ADDR_PRESCALE_CTRL = {2'h0, IDX_PRESCALE_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_CLOCK_CTRL = {2'h0, IDX_CLOCK_CTRL, 2'h0};

  // Field positions and reset values
  localparam int unsigned SEL_MSB = 2;
  localparam int unsigned FLAGS_LSB = 3;
  localparam int unsigned TO_BIT = 5;
  localparam int unsigned PDF_BIT = 4;
  localparam int unsigned SCLK_BIT = 0;
  localparam logic [7:0] PRESCALE_RST = 8'h87;
  localparam logic [4:0] FLAGS_PATTERN = 5'h10;
  localparam logic SCLK_RST = 1'b1;

  // Power state
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_DELAY = 3'b100
  } wdh_state_t;

endpackage : wdh_pkg

// [hdl/wdh_watchdog_halt.sv]
`timescale 1ns/1ps
// Functional notes
// RULE1 - Watchdog clock: RC oscillator or instruction clock
// RULE2 - Disabled watchdog makes all its operations void
// RULE3 - RC clock first divided by 256
// RULE4 - Select bits 2..0 add 2^N division
// RULE5 - Instruction-clock watchdog may stop during halt
// RULE6 - Bits 7..3 user flags, pattern 10000 only
// RULE7 - Overflow when running: chip reset, timeout flag
// RULE8 - Overflow when halted: warm reset, timeout flag
// RULE9 - Reset pin, clear, halt clear the watchdog
// RULE10 - Single or dual clear instruction mode
// RULE11 - Halt stops system clock, RC keeps running
// RULE12 - Halt leaves registers and ports unchanged
// RULE13 - RC-clocked halt restarts watchdog from zero
// RULE14 - Halt sets powerdown flag, clears timeout flag
// RULE15 - Powerdown cleared by power-up or clear
// RULE16 - Wake on reset, interrupt, port fall, overflow
// RULE17 - Per-bit port A wake, resume next instruction
// RULE18 - Interrupt wake: vector if enabled, stack free
// RULE19 - Already pending interrupt cannot wake
// RULE20 - 1024 system clock delay after wake
// RULE21 - System clock 6 or 12 MHz, default 12
// RULE22 - RC oscillator option, runs during powerdown
// RULE23 - Timeout flag in status bit 5
// RULE24 - Powerdown flag in status bit 4
// RULE25 - Overflow one-cycle pulse, counter wraps
module wdh_watchdog_halt #(
  parameter bit WDT_ENABLE = 1'b1,       // Watchdog present
  parameter bit WDT_CLK_RC = 1'b1,       // Watchdog clocked from RC oscillator
  parameter bit RC_OSC_ENABLE = 1'b1,    // RC oscillator fitted
  parameter bit DUAL_CLEAR = 1'b0,       // Two clear instructions needed
  parameter logic [7:0] WAKE_MASK_PA = 8'hff  // Port A bits allowed to wake
) (
  input wire logic pclk,                 // Bus and logic clock
  input wire logic presetn,              // Power-up reset, active low
  input wire logic psel,                 // APB select
  input wire logic penable,              // APB enable
  input wire logic pwrite,               // APB direction
  input wire logic [11:0] paddr,         // APB byte address
  input wire logic [31:0] pwdata,        // APB write data
  output logic [31:0] prdata,            // APB read data
  output logic pready,                   // APB ready
  output logic pslverr,                  // APB error on unmapped address
  input wire logic external_reset_pin_n, // Reset pin, asynchronous
  input wire logic [7:0] port_a,         // Port A pins, asynchronous
  input wire logic watchdog_clear_single, // Single clear executed
  input wire logic watchdog_clear_first, // First of dual clear executed
  input wire logic watchdog_clear_second, // Second of dual clear executed
  input wire logic halt_exec,            // Halt instruction executed
  input wire logic [2:0] int_req,        // Interrupt request flags
  input wire logic [2:0] int_enable,     // Per-source interrupt enables
  input wire logic int_global_en,        // Master interrupt enable
  input wire logic stack_full,           // Stack has no free level
  output logic chip_reset,               // Full chip reset request
  output logic warm_reset,               // Reset of program counter and stack pointer
  output logic core_run,                 // Core may execute
  output logic halted,                   // Device in power-down
  output logic resume_next,              // Resume at instruction after halt
  output logic take_interrupt,           // Take interrupt vector after wake
  output logic wdt_overflow,             // Watchdog overflow pulse
  output logic timeout_flag,             // Timeout status flag
  output logic powerdown_flag,           // Powerdown status flag
  output logic sysclk_select_bit         // 1 selects 12 MHz system clock
);

  localparam bit RC_SRC = WDT_CLK_RC && RC_OSC_ENABLE;

  wdh_pkg::wdh_state_t state_ff, nxt_state;
  logic rst_meta_ff, rst_sync_ff;
  logic [7:0] pa_meta_ff, pa_sync_ff, pa_prev_ff;
  logic [4:0] sys_div_ff;
  logic [1:0] instr_div_ff;
  logic [11:0] rc_div_ff;
  logic [wdh_pkg::CNT_W-1:0] wdt_cnt_ff;
  logic got_first_ff, got_second_ff;
  logic to_ff, pdf_ff;
  logic [7:0] prescale_ff;
  logic sclk_ff;
  logic [2:0] int_at_halt_ff;
  logic woke_int_ff, woke_port_ff;
  logic [10:0] sst_cnt_ff;
  logic [31:0] prdata_ff;

  // Reset pin and port A pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= 1'b1;
      pa_meta_ff <= 8'hff;
      pa_sync_ff <= 8'hff;
      pa_prev_ff <= 8'hff;
    end else begin
      rst_meta_ff <= external_reset_pin_n;
      rst_sync_ff <= rst_meta_ff;
      pa_meta_ff <= port_a;
      pa_sync_ff <= pa_meta_ff;
      pa_prev_ff <= pa_sync_ff;
    end
  end

  wire rst_pin_low = !rst_sync_ff;
  wire st_run = (state_ff == wdh_pkg::ST_RUN);
  wire st_halt = (state_ff == wdh_pkg::ST_HALT);
  wire st_delay = (state_ff == wdh_pkg::ST_DELAY);

  // System clock model: stopped while halted
  wire [4:0] sys_div_last = sclk_ff ? 5'(wdh_pkg::SYS_FAST_CYC - 1) :
                                      5'(wdh_pkg::SYS_SLOW_CYC - 1);  // RULE21
  wire sys_run = !st_halt;  // RULE11
  wire sys_tick = sys_run && (sys_div_ff >= sys_div_last);
  wire instr_tick = sys_tick && (instr_div_ff == 2'(wdh_pkg::INSTR_DIV - 1));
  wire rc_tick = RC_OSC_ENABLE && (rc_div_ff == 12'(wdh_pkg::RC_CYC - 1));  // RULE22
  wire wdt_tick = WDT_ENABLE && (RC_SRC ? rc_tick : instr_tick);  // RULE1 RULE5

  // Clock dividers; the RC oscillator is free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_div_ff <= 5'h00;
      instr_div_ff <= 2'h0;
      rc_div_ff <= 12'h000;
    end else begin
      sys_div_ff <= !sys_run ? sys_div_ff : (sys_tick ? 5'h00 : sys_div_ff + 5'h01);
      instr_div_ff <= sys_tick ? instr_div_ff + 2'h1 : instr_div_ff;
      rc_div_ff <= rc_tick ? 12'h000 : rc_div_ff + 12'h001;
    end
  end

  // Terminal count: 256 base times 2^N prescale
  wire [2:0] prescale_sel = prescale_ff[wdh_pkg::SEL_MSB:0];  // RULE4
  wire [3:0] term_shift = 4'(wdh_pkg::BASE_STAGES) + {1'b0, prescale_sel};  // RULE3
  wire [15:0] term_one = 16'h0001 << term_shift;
  wire [wdh_pkg::CNT_W-1:0] wdt_term = 15'(term_one - 16'h0001);
  assign wdt_overflow = wdt_tick && (wdt_cnt_ff == wdt_term);  // RULE25

  // Clear instruction decoding, single or dual mode
  wire clr_single = WDT_ENABLE && !DUAL_CLEAR && watchdog_clear_single;
  wire have_first = got_first_ff || watchdog_clear_first;
  wire have_second = got_second_ff || watchdog_clear_second;
  wire clr_dual = WDT_ENABLE && DUAL_CLEAR && have_first && have_second;
  wire wdt_clear_instr = clr_single || clr_dual;  // RULE10 RULE2
  wire halt_enter = halt_exec && st_run;
  wire wdt_clear = wdt_clear_instr || halt_enter || rst_pin_low;  // RULE9 RULE13

  // Watchdog counter, wraps after overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_ff <= '0;
    end else if (wdt_clear || wdt_overflow) begin
      wdt_cnt_ff <= '0;  // RULE9 RULE25
    end else if (wdt_tick) begin
      wdt_cnt_ff <= wdt_cnt_ff + 15'h0001;
    end
  end

  // Dual clear bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got_first_ff <= 1'b0;
      got_second_ff <= 1'b0;
    end else begin
      got_first_ff <= DUAL_CLEAR && WDT_ENABLE && have_first && !clr_dual && !rst_pin_low;
      got_second_ff <= DUAL_CLEAR && WDT_ENABLE && have_second && !clr_dual && !rst_pin_low;
    end
  end

  // Wake sources while halted
  wire [2:0] int_fresh = int_req & ~int_at_halt_ff;  // RULE19
  wire int_wake = st_halt && (|int_fresh);
  wire [7:0] pa_fall = pa_prev_ff & ~pa_sync_ff & WAKE_MASK_PA;  // RULE17
  wire port_wake = st_halt && (|pa_fall);
  wire ovf_wake = st_halt && wdt_overflow;
  wire any_wake = int_wake || port_wake || ovf_wake || (st_halt && rst_pin_low);  // RULE16
  wire sst_done = sys_tick && (sst_cnt_ff == 11'(wdh_pkg::SST_TICKS - 1));
  wire int_taken = |(int_fresh & int_enable);

  // Power state sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      wdh_pkg::ST_RUN: begin
        if (rst_pin_low || wdt_overflow) begin
          nxt_state = wdh_pkg::ST_DELAY;  // RULE7
        end else if (halt_exec) begin
          nxt_state = wdh_pkg::ST_HALT;
        end
      end
      wdh_pkg::ST_HALT: begin
        if (any_wake) begin
          nxt_state = wdh_pkg::ST_DELAY;  // RULE16
        end
      end
      wdh_pkg::ST_DELAY: begin
        if (sst_done && !rst_pin_low) begin
          nxt_state = wdh_pkg::ST_RUN;  // RULE20
        end
      end
      default: nxt_state = wdh_pkg::ST_DELAY;
    endcase
  end

  // State, wake cause and start-up delay counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= wdh_pkg::ST_DELAY;
      sst_cnt_ff <= 11'h000;
      int_at_halt_ff <= 3'h0;
      woke_int_ff <= 1'b0;
      woke_port_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (!st_delay || rst_pin_low) begin
        sst_cnt_ff <= 11'h000;
      end else if (sys_tick) begin
        sst_cnt_ff <= sst_cnt_ff + 11'h001;  // RULE20
      end
      if (halt_enter) begin
        int_at_halt_ff <= int_req;  // RULE19
      end
      if (st_halt && any_wake) begin
        woke_int_ff <= int_wake && !ovf_wake && !rst_pin_low;
        woke_port_ff <= port_wake && !int_wake && !ovf_wake && !rst_pin_low;
      end else if (st_run || rst_pin_low) begin
        woke_int_ff <= 1'b0;
        woke_port_ff <= 1'b0;
      end
      if (st_halt && any_wake && int_wake) begin
        int_at_halt_ff <= int_at_halt_ff;
      end
    end
  end

  // Reset requests and resume decisions
  assign chip_reset = rst_pin_low || (st_run && wdt_overflow);  // RULE7
  assign warm_reset = ovf_wake;  // RULE8
  assign core_run = st_run;
  assign halted = st_halt;  // RULE12
  wire resume_edge = st_delay && sst_done && !rst_pin_low;
  wire int_vector = int_global_en && int_taken && !stack_full;  // RULE18
  assign take_interrupt = resume_edge && woke_int_ff && int_vector;
  assign resume_next = resume_edge && (woke_port_ff || (woke_int_ff && !int_vector));  // RULE17

  // Status flags; a timeout set wins over any clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_ff <= 1'b0;
      pdf_ff <= 1'b0;
    end else begin
      if (wdt_overflow) begin
        to_ff <= 1'b1;  // RULE7 RULE8 RULE15
      end else if (wdt_clear_instr || halt_enter || (st_halt && rst_pin_low)) begin
        to_ff <= 1'b0;  // RULE23
      end
      if (halt_enter) begin
        pdf_ff <= 1'b1;  // RULE14
      end else if (wdt_clear_instr || (st_halt && rst_pin_low)) begin
        pdf_ff <= 1'b0;  // RULE15
      end
    end
  end
  assign timeout_flag = to_ff;
  assign powerdown_flag = pdf_ff;

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_write = psel && penable && pwrite;
  wire hit_prescale = (paddr == wdh_pkg::ADDR_PRESCALE_CTRL);
  wire hit_status = (paddr == wdh_pkg::ADDR_STATUS);
  wire hit_clock = (paddr == wdh_pkg::ADDR_CLOCK_CTRL);
  wire hit_any = hit_prescale || hit_status || hit_clock;
  wire flags_ok = (pwdata[7:wdh_pkg::FLAGS_LSB] == wdh_pkg::FLAGS_PATTERN);
  // Flags are widened before shifting so that no bit is lost
  wire [7:0] status_rd = ({7'h00, to_ff} << wdh_pkg::TO_BIT) |
                         ({7'h00, pdf_ff} << wdh_pkg::PDF_BIT);  // RULE23 RULE24
  wire [7:0] clock_rd = {7'h00, sclk_ff} << wdh_pkg::SCLK_BIT;
  wire [7:0] rd_mux = hit_prescale ? prescale_ff :
                      hit_status ? status_rd :
                      hit_clock ? clock_rd : 8'h00;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = prdata_ff;

  // Writable registers; reset pin restores the prescale control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_ff <= wdh_pkg::PRESCALE_RST;
      sclk_ff <= wdh_pkg::SCLK_RST;
      prdata_ff <= 32'h0000_0000;
    end else begin
      if (rst_pin_low) begin
        prescale_ff <= wdh_pkg::PRESCALE_RST;
      end else if (apb_write && hit_prescale) begin
        prescale_ff[wdh_pkg::SEL_MSB:0] <= pwdata[wdh_pkg::SEL_MSB:0];
        if (flags_ok) begin
          prescale_ff[7:wdh_pkg::FLAGS_LSB] <= pwdata[7:wdh_pkg::FLAGS_LSB];  // RULE6
        end
      end
      if (apb_write && hit_clock) begin
        sclk_ff <= pwdata[wdh_pkg::SCLK_BIT];  // RULE21
      end
      if (apb_setup && !pwrite) begin
        prdata_ff <= {24'h000000, rd_mux};
      end
    end
  end
  assign sysclk_select_bit = sclk_ff;

  // Checks
  default clocking chk_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence halt_entry_s;
    halt_enter && !wdt_overflow && !rst_pin_low;
  endsequence

  sequence halted_flags_s;
    pdf_ff && !to_ff && st_halt;
  endsequence

  ovf_wraps_a: assert property (wdt_overflow |=> wdt_cnt_ff == '0)  // RULE25
    else $error("counter did not wrap after overflow");
  halt_flags_a: assert property (halt_entry_s |=> halted_flags_s)  // RULE14
    else $error("halt entry flags wrong");
  to_set_a: assert property (wdt_overflow |=> to_ff)  // RULE7
    else $error("timeout flag not set");
  run_reset_a: assert property (st_run && wdt_overflow |-> chip_reset ##1 st_delay)  // RULE7
    else $error("overflow in run did not reset");
  halt_warm_a: assert property (st_halt && wdt_overflow |-> warm_reset && !chip_reset)  // RULE8
    else $error("overflow in halt not warm reset");
  dual_clear_a: assert property (wdt_clear_instr && DUAL_CLEAR |-> have_first && have_second)  // RULE10
    else $error("dual clear fired early");
  sst_len_a: assert property ($rose(st_run) |-> $past(sst_cnt_ff) == 11'(wdh_pkg::SST_TICKS - 1))  // RULE20
    else $error("resume before start-up delay");
  flags_fixed_a: assert property (prescale_ff[7:wdh_pkg::FLAGS_LSB] == wdh_pkg::FLAGS_PATTERN)  // RULE6
    else $error("user flag bits left pattern");
  halt_stop_a: assert property (st_halt && !RC_SRC |-> !wdt_tick)  // RULE5
    else $error("instruction clock ran in halt");
  wdt_off_a: assert property (!WDT_ENABLE |-> !wdt_overflow && !wdt_clear_instr)  // RULE2
    else $error("disabled watchdog acted");
  stale_int_a: assert property (st_halt && int_req == int_at_halt_ff |-> !int_wake)  // RULE19
    else $error("pending interrupt woke device");
  term_len_a: assert property (wdt_overflow |-> wdt_cnt_ff == wdt_term && wdt_term[7:0] == 8'hff)  // RULE3
    else $error("base divider not 256");

endmodule : wdh_watchdog_halt

// [dv/wdh_core_model.sv]
`timescale 1ns/1ps
module wdh_core_model (
  input wire logic pclk, // Logic clock
  input wire logic core_run, // Core may execute
  output logic clr_single, // Single clear pulse
  output logic clr_first, // First dual clear pulse
  output logic clr_second, // Second dual clear pulse
  output logic halt_exec, // Halt pulse
  output logic [2:0] int_req, // Interrupt request flags
  output logic [2:0] int_enable, // Interrupt enables
  output logic int_global_en, // Master enable
  output logic stack_full // Stack full
);
  // Idle core outputs from time zero
  initial begin
    {clr_single, clr_first, clr_second, halt_exec} = 4'h0;
    {int_req, int_enable, int_global_en, stack_full} = 8'h00;
  end

  // One clear instruction: 0 single, 1 first, 2 second
  task automatic pulse_clear(input int kind);
    @(posedge pclk);
    clr_single <= (kind == 0);
    clr_first <= (kind == 1);
    clr_second <= (kind == 2);
    @(posedge pclk);
    {clr_single, clr_first, clr_second} <= 3'h0;
  endtask : pulse_clear

  // A halt is only executed by a running core
  task automatic do_halt();
    @(posedge pclk);
    if (core_run === 1'b1) halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
  endtask : do_halt

  // Interrupt side levels
  task automatic set_int(input logic [2:0] req, input logic [2:0] en, input logic gl,
                         input logic sf);
    @(posedge pclk);
    int_req <= req;
    int_enable <= en;
    int_global_en <= gl;
    stack_full <= sf;
  endtask : set_int
endmodule : wdh_core_model

// [dv/test_watchdog_and_halt_control.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_watchdog_and_halt_control;
  localparam int OV = (1 << wdh_pkg::BASE_STAGES) * wdh_pkg::INSTR_DIV * wdh_pkg::SYS_FAST_CYC;
  localparam int SST = wdh_pkg::SST_TICKS * wdh_pkg::SYS_FAST_CYC;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, chip_reset, warm_reset, core_run, halted, resume_next, take_interrupt;
  logic wdt_overflow, timeout_flag, powerdown_flag, sysclk_select_bit, err;
  logic pin_n = 1'b1;
  logic [7:0] port_a = 8'hff;
  logic clr_s, clr_f, clr_2, halt_exec, int_gl, stack_full;
  logic [2:0] int_req, int_en;
  int fail_count = 0, samples_checked = 0, n_res = 0, n_take = 0, n_ov = 0, n_warm = 0, n;

  wdh_watchdog_halt #(.WDT_CLK_RC(1'b0)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_reset_pin_n(pin_n), .port_a(port_a),
    .watchdog_clear_single(clr_s), .watchdog_clear_first(clr_f), .watchdog_clear_second(clr_2),
    .halt_exec(halt_exec), .int_req(int_req), .int_enable(int_en), .int_global_en(int_gl),
    .stack_full(stack_full), .chip_reset(chip_reset), .warm_reset(warm_reset),
    .core_run(core_run), .halted(halted), .resume_next(resume_next),
    .take_interrupt(take_interrupt), .wdt_overflow(wdt_overflow), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .sysclk_select_bit(sysclk_select_bit));

  wdh_core_model i_core (.pclk(pclk), .core_run(core_run), .clr_single(clr_s),
    .clr_first(clr_f), .clr_second(clr_2), .halt_exec(halt_exec), .int_req(int_req),
    .int_enable(int_en), .int_global_en(int_gl), .stack_full(stack_full));

  // Clock and pulse counters
  always #(wdh_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;
  always @(posedge pclk) begin
    if (resume_next === 1'b1) n_res++;
    if (take_interrupt === 1'b1) n_take++;
    if (wdt_overflow === 1'b1) n_ov++;
    if (warm_reset === 1'b1) n_warm++;
  end

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rd_chk

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : cyc

  task automatic wait_run();
    n = 0;
    while (core_run !== 1'b1 && n < 20000) begin @(posedge pclk); #1; n++; end
    `CHK(core_run, 1'b1)
  endtask : wait_run

  task automatic stop_test();
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  // Hang guard
  initial begin
    #(90000 * wdh_pkg::CLK_PERIOD_NS);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Register reset values, access kinds and the unmapped place
    rd_chk(wdh_pkg::ADDR_PRESCALE_CTRL, 32'h87);
    rd_chk(wdh_pkg::ADDR_STATUS, 32'h0);
    rd_chk(wdh_pkg::ADDR_CLOCK_CTRL, 32'h1);
    rd_chk(12'h100, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, wdh_pkg::ADDR_PRESCALE_CTRL, 32'h83);
    rd_chk(wdh_pkg::ADDR_PRESCALE_CTRL, 32'h83);
    apb(1'b1, wdh_pkg::ADDR_PRESCALE_CTRL, 32'h0d);
    rd_chk(wdh_pkg::ADDR_PRESCALE_CTRL, 32'h85);
    apb(1'b1, wdh_pkg::ADDR_PRESCALE_CTRL, 32'h80);
    apb(1'b1, wdh_pkg::ADDR_STATUS, 32'hff);
    rd_chk(wdh_pkg::ADDR_STATUS, 32'h0);
    apb(1'b1, wdh_pkg::ADDR_CLOCK_CTRL, 32'h0);
    #1;
    `CHK(sysclk_select_bit, 1'b0)
    apb(1'b1, wdh_pkg::ADDR_CLOCK_CTRL, 32'h1);
    wait_run();
    `CHK(core_run, 1'b1)
    // Periodic clears keep the watchdog quiet, then it overflows
    i_core.pulse_clear(0);
    n_ov = 0;
    cyc(OV - 2000);
    i_core.pulse_clear(0);
    cyc(OV - 2000);
    `CHK(n_ov, 0)
    i_core.pulse_clear(0);
    cyc(2000);
    // In single-clear mode the dual-clear pair must not restart the count
    i_core.pulse_clear(1);
    i_core.pulse_clear(2);
    n = 0;
    while (wdt_overflow !== 1'b1 && n < 20000) begin @(posedge pclk); #1; n++; end
    `CHK(n >= OV - 2064 && n <= OV - 1936, 1'b1)
    `CHK(chip_reset, 1'b1)
    cyc(1);
    `CHK(wdt_overflow, 1'b0)
    `CHK(timeout_flag, 1'b1)
    rd_chk(wdh_pkg::ADDR_STATUS, 32'h20);
    wait_run();
    // Halt and port wake
    i_core.do_halt();
    cyc(2);
    `CHK({halted, core_run, powerdown_flag, timeout_flag}, 4'ha)
    rd_chk(wdh_pkg::ADDR_STATUS, 32'h10);
    cyc(100);
    `CHK(halted, 1'b1)
    n_res = 0;
    @(posedge pclk);
    port_a <= 8'hfb;
    wait_run();
    `CHK(n >= SST - wdh_pkg::SYS_FAST_CYC && n <= SST + 24, 1'b1)
    `CHK(n_res, 1)
    @(posedge pclk);
    port_a <= 8'hff;
    i_core.pulse_clear(0);
    cyc(2);
    `CHK({powerdown_flag, timeout_flag}, 2'b00)
    // Pending request cannot wake; fresh one wakes, vector only with free stack
    for (int sf = 0; sf < 2; sf++) begin
      i_core.set_int(3'b001, 3'b010, 1'b1, sf[0]);
      i_core.do_halt();
      cyc(200);
      `CHK(halted, 1'b1)
      n_res = 0;
      n_take = 0;
      i_core.set_int(3'b011, 3'b010, 1'b1, sf[0]);
      wait_run();
      `CHK(n_take == (sf == 0), 1'b1)
      `CHK(n_res == sf, 1'b1)
      i_core.set_int(3'b000, 3'b000, 1'b0, 1'b0);
      i_core.pulse_clear(0);
    end
    // Reset pin restores the prescaler reset value and resets the chip
    apb(1'b1, wdh_pkg::ADDR_PRESCALE_CTRL, 32'h84);
    @(posedge pclk);
    pin_n <= 1'b0;
    cyc(4);
    `CHK(chip_reset, 1'b1)
    @(posedge pclk);
    pin_n <= 1'b1;
    rd_chk(wdh_pkg::ADDR_PRESCALE_CTRL, 32'h87);
    wait_run();
    `CHK(core_run, 1'b1)
    `CHK(n_warm, 0)
    stop_test();
  end
endmodule : test_watchdog_and_halt_control
